//--- src/fcs_top.sv
`include "fcs_cfg.svh"
module fcs_top (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [3:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    input wire logic fp_issue,
    output logic fp_go,
    output logic fp_stall,
    output logic coprocessor_absent_fault,
    input wire logic exc_entry,
    input wire logic exc_return,
    output logic [7:0] frame_words,
    output logic [7:0] fp_save_words,
    output logic fp_save_now,
    input wire logic fp_save_done,
    output logic fp_restore,
    output fcs_pkg::fcs_arith_t arith_mode,
    output logic irq
);
    fcs_frame_if fi ();

    logic [2:0] ctrl_ff, nxt_ctrl;
    logic [4:0] mode_ff, nxt_mode;
    fcs_pkg::fcs_arith_t arith_ff, nxt_arith;
    logic used_ff, nxt_used;
    logic [2:0] ist_ff, nxt_ist;
    logic [2:0] ien_ff, nxt_ien;
    logic [31:0] rdata_ff, nxt_rdata;
    logic fault_ff, nxt_fault;
    logic enabled;
    fcs_pkg::fcs_stack_t stk_mode;
    logic [2:0] ev;

    // decode of the two-bit stacking field
    function automatic fcs_pkg::fcs_stack_t stk_decode(input logic [1:0] f);
        unique case (f)
            2'h0: stk_decode = fcs_pkg::fcs_stack_none;
            2'h1: stk_decode = fcs_pkg::fcs_stack_full;
            default: stk_decode = fcs_pkg::fcs_stack_lazy;
        endcase
    endfunction

    assign enabled = ctrl_ff[`FCS_B_EN];
    assign stk_mode = stk_decode(ctrl_ff[`FCS_B_STK1:`FCS_B_STK0]);

    fcs_frame u_frame (
        .clk(clk),
        .nrst(nrst),
        .mode(stk_mode),
        .fi(fi.frm)
    );

    // link to the frame tracker
    assign fi.entry = exc_entry;
    assign fi.ret = exc_return;
    assign fi.fp_insn = fp_issue && enabled;
    assign fi.save_done = fp_save_done;

    // issue gating: disabled faults, lazy save stalls, else go
    always_comb begin
        fp_go = fp_issue && enabled && !fi.save_go;
        fp_stall = fp_issue && enabled && fi.save_go;
    end
    assign fp_save_now = fi.save_go;
    assign fp_restore = fi.restore;
    assign frame_words = fi.frame_words;
    assign fp_save_words = `FCS_CTX_WORDS;
    assign coprocessor_absent_fault = fault_ff;
    assign arith_mode = arith_ff;
    assign reg_rdata = rdata_ff;
    assign irq = |(ist_ff & ien_ff);

    // events feeding the sticky status
    always_comb begin
        ev = 3'h0;
        ev[`FCS_I_FAULT] = fp_issue && !enabled;
        ev[`FCS_I_LAZY] = fp_save_done && fi.save_go;
        ev[`FCS_I_NW] = reg_wr && reg_addr == `FCS_A_MODE && used_ff;
    end

    // register writes, settings lock and status
    always_comb begin
        nxt_ctrl = ctrl_ff;
        nxt_mode = mode_ff;
        nxt_arith = arith_ff;
        nxt_used = used_ff;
        nxt_ien = ien_ff;
        nxt_ist = ist_ff;
        nxt_fault = fp_issue && !enabled;
        if (reg_wr) begin
            unique case (reg_addr)
                `FCS_A_CTRL: nxt_ctrl = reg_wdata[2:0];
                `FCS_A_MODE: nxt_mode = reg_wdata[4:0];
                `FCS_A_ICLR: nxt_ist = ist_ff & ~reg_wdata[2:0];
                `FCS_A_IEN: nxt_ien = reg_wdata[2:0];
                default: ;
            endcase
        end
        nxt_ist = nxt_ist | ev; // set wins over clear
        // settings captured by the first executed instruction
        if (fp_go && !used_ff) begin
            nxt_used = 1'b1;
            nxt_arith.flush = fcs_pkg::fcs_flush_t'(mode_ff[`FCS_B_FZ]);
            nxt_arith.half = fcs_pkg::fcs_half_t'(mode_ff[`FCS_B_AHP]);
            nxt_arith.nan = fcs_pkg::fcs_nan_t'(mode_ff[`FCS_B_DN]);
            nxt_arith.round = fcs_pkg::fcs_round_t'(mode_ff[`FCS_B_RM1:`FCS_B_RM0]);
        end
    end

    // read mux, data one cycle after the strobe
    always_comb begin
        nxt_rdata = 32'h0;
        if (reg_rd) begin
            unique case (reg_addr)
                `FCS_A_CTRL: nxt_rdata = {29'h0, ctrl_ff};
                `FCS_A_MODE: nxt_rdata = {27'h0, mode_ff};
                `FCS_A_STAT: nxt_rdata = {22'h0, fi.frame_words, fi.ctx_written, used_ff};
                `FCS_A_ISTAT: nxt_rdata = {29'h0, ist_ff};
                `FCS_A_IEN: nxt_rdata = {29'h0, ien_ff};
                default: nxt_rdata = 32'h0;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            ctrl_ff <= `FCS_CTRL_RST;
            mode_ff <= `FCS_MODE_RST;
            arith_ff <= '0;
            used_ff <= 1'b0;
            ist_ff <= 3'h0;
            ien_ff <= 3'h0;
            rdata_ff <= 32'h0;
            fault_ff <= 1'b0;
        end else begin
            ctrl_ff <= nxt_ctrl;
            mode_ff <= nxt_mode;
            arith_ff <= nxt_arith;
            used_ff <= nxt_used;
            ist_ff <= nxt_ist;
            ien_ff <= nxt_ien;
            rdata_ff <= nxt_rdata;
            fault_ff <= nxt_fault;
        end
    end

    // a floating-point issue while the unit is off
    sequence s_disabled_issue;
        fp_issue && !enabled;
    endsequence
    // the fault pulse that follows it
    sequence s_fault_next;
        coprocessor_absent_fault;
    endsequence
    // a fault event and a clear of its status bit in one cycle
    sequence s_fault_vs_clear;
        fp_issue && !enabled && reg_wr && reg_addr == `FCS_A_ICLR
            && reg_wdata[`FCS_I_FAULT];
    endsequence
    // first executed instruction while the settings are open
    sequence s_first_insn;
        fp_go && !used_ff;
    endsequence
    // lazy save still waiting for the core
    sequence s_save_wait;
        fp_save_now && !fp_save_done && !exc_entry && !exc_return;
    endsequence
    // lazy save reported done by the core
    sequence s_save_finish;
        fp_save_now && fp_save_done && !exc_entry && !exc_return;
    endsequence
    // a mode write that arrives after the lock
    sequence s_late_mode_wr;
        reg_wr && reg_addr == `FCS_A_MODE && used_ff;
    endsequence

    // issue gating and the missing-unit fault
    a_fault_when_off: assert property (@(posedge clk) disable iff (!nrst)
        s_disabled_issue |-> !fp_go ##1 s_fault_next)
        else $error("no fault while disabled");
    a_fault_only_off: assert property (@(posedge clk) disable iff (!nrst)
        !(fp_issue && !enabled) |=> !coprocessor_absent_fault)
        else $error("fault without a blocked insn");
    a_off_no_go: assert property (@(posedge clk) disable iff (!nrst)
        !enabled |-> !fp_go && !fp_stall)
        else $error("insn ran while disabled");
    a_go_only_on: assert property (@(posedge clk) disable iff (!nrst)
        fp_go |-> enabled && fp_issue)
        else $error("go without an enabled issue");
    a_go_when_on: assert property (@(posedge clk) disable iff (!nrst)
        fp_issue && enabled && !fp_save_now |-> fp_go)
        else $error("enabled insn blocked");
    a_stall_no_go: assert property (@(posedge clk) disable iff (!nrst)
        fp_save_now && fp_issue && enabled |-> fp_stall && !fp_go)
        else $error("insn ran before save");

    // arithmetic settings lock at the first executed instruction
    a_settings_locked: assert property (@(posedge clk) disable iff (!nrst)
        used_ff |=> $stable(arith_mode))
        else $error("mode changed after first insn");
    a_first_locks: assert property (@(posedge clk) disable iff (!nrst)
        s_first_insn |=> used_ff)
        else $error("settings not locked");
    a_late_write_flag: assert property (@(posedge clk) disable iff (!nrst)
        s_late_mode_wr |=> ist_ff[`FCS_I_NW])
        else $error("late mode write not flagged");
    a_flush_capture: assert property (@(posedge clk) disable iff (!nrst)
        s_first_insn |=> arith_mode.flush == fcs_pkg::fcs_flush_t'($past(mode_ff[`FCS_B_FZ])))
        else $error("flush not captured");
    a_half_capture: assert property (@(posedge clk) disable iff (!nrst)
        s_first_insn |=> arith_mode.half == fcs_pkg::fcs_half_t'($past(mode_ff[`FCS_B_AHP])))
        else $error("half format not captured");
    a_nan_capture: assert property (@(posedge clk) disable iff (!nrst)
        s_first_insn |=> arith_mode.nan == fcs_pkg::fcs_nan_t'($past(mode_ff[`FCS_B_DN])))
        else $error("nan mode not captured");
    a_first_capture: assert property (@(posedge clk) disable iff (!nrst)
        s_first_insn |=> arith_mode.round
            == fcs_pkg::fcs_round_t'($past(mode_ff[`FCS_B_RM1:`FCS_B_RM0])))
        else $error("rounding not captured");

    // context stacking and frame size
    a_save_held: assert property (@(posedge clk) disable iff (!nrst)
        s_save_wait |=> fp_save_now)
        else $error("save request dropped early");
    a_save_releases: assert property (@(posedge clk) disable iff (!nrst)
        s_save_finish |=> !fp_save_now && !fp_stall)
        else $error("stall held after save");
    a_lazy_event: assert property (@(posedge clk) disable iff (!nrst)
        s_save_finish |=> ist_ff[`FCS_I_LAZY])
        else $error("lazy save not flagged");
    a_restore_written: assert property (@(posedge clk) disable iff (!nrst)
        exc_return && fi.ctx_written |-> fp_restore)
        else $error("written context not restored");
    a_none_no_save: assert property (@(posedge clk) disable iff (!nrst)
        stk_mode == fcs_pkg::fcs_stack_none && exc_entry |=> !fp_save_now)
        else $error("save with stacking off");
    a_frame_size: assert property (@(posedge clk) disable iff (!nrst)
        frame_words == ((stk_mode == fcs_pkg::fcs_stack_none) ? `FCS_FRAME_INT : `FCS_FRAME_FP))
        else $error("wrong frame size");
    a_save_words: assert property (@(posedge clk) disable iff (!nrst)
        fp_save_words == `FCS_FRAME_FP - `FCS_FRAME_INT)
        else $error("wrong context size");

    // status bits and the register port
    a_fault_sticky: assert property (@(posedge clk) disable iff (!nrst)
        coprocessor_absent_fault |-> ist_ff[`FCS_I_FAULT])
        else $error("fault not in status");
    a_set_beats_clear: assert property (@(posedge clk) disable iff (!nrst)
        s_fault_vs_clear |=> ist_ff[`FCS_I_FAULT])
        else $error("clear beat a new fault");
    a_clear_works: assert property (@(posedge clk) disable iff (!nrst)
        reg_wr && reg_addr == `FCS_A_ICLR && reg_wdata[`FCS_I_FAULT] && enabled
            |=> !ist_ff[`FCS_I_FAULT])
        else $error("fault status not cleared");
    a_ctrl_write: assert property (@(posedge clk) disable iff (!nrst)
        reg_wr && reg_addr == `FCS_A_CTRL |=> ctrl_ff == $past(reg_wdata[2:0]))
        else $error("control write lost");
    a_ien_write: assert property (@(posedge clk) disable iff (!nrst)
        reg_wr && reg_addr == `FCS_A_IEN |=> ien_ff == $past(reg_wdata[2:0]))
        else $error("enable write lost");
    a_read_idle: assert property (@(posedge clk) disable iff (!nrst)
        !reg_rd |=> reg_rdata == 32'h0)
        else $error("read data outside its cycle");
    a_read_ctrl: assert property (@(posedge clk) disable iff (!nrst)
        reg_rd && reg_addr == `FCS_A_CTRL |=> reg_rdata[2:0] == $past(ctrl_ff))
        else $error("control read wrong");
    a_read_mode: assert property (@(posedge clk) disable iff (!nrst)
        reg_rd && reg_addr == `FCS_A_MODE |=> reg_rdata[4:0] == $past(mode_ff))
        else $error("mode read wrong");
    a_read_istat: assert property (@(posedge clk) disable iff (!nrst)
        reg_rd && reg_addr == `FCS_A_ISTAT |=> reg_rdata[2:0] == $past(ist_ff))
        else $error("status read wrong");
    a_read_frame: assert property (@(posedge clk) disable iff (!nrst)
        reg_rd && reg_addr == `FCS_A_STAT |=> reg_rdata[9:2] == $past(frame_words))
        else $error("frame size read wrong");
    a_read_unmapped: assert property (@(posedge clk) disable iff (!nrst)
        reg_rd && (reg_addr == `FCS_A_ICLR || reg_addr > `FCS_A_IEN)
            |=> reg_rdata == 32'h0)
        else $error("unmapped read not zero");

    // reset defaults
    a_reset_defaults: assert property (@(posedge clk)
        !nrst |=> !enabled && stk_mode == fcs_pkg::fcs_stack_lazy)
        else $error("bad reset defaults");
    a_reset_flush: assert property (@(posedge clk)
        !nrst |=> arith_mode.flush == fcs_pkg::denormal_flush_off)
        else $error("flush not default off");
    a_lazy_reset: assert property (@(posedge clk)
        !nrst |=> ctrl_ff == `FCS_CTRL_RST)
        else $error("stacking not lazy at reset");
endmodule

//--- src/fcs_cfg.svh
`ifndef FCS_CFG_SVH
`define FCS_CFG_SVH
// register indices (word address = index * 4)
`define FCS_A_CTRL 4'h0
`define FCS_A_MODE 4'h1
`define FCS_A_STAT 4'h2
`define FCS_A_ISTAT 4'h3
`define FCS_A_ICLR 4'h4
`define FCS_A_IEN 4'h5
// control register fields
`define FCS_B_EN 0
`define FCS_B_STK0 1
`define FCS_B_STK1 2
// mode register fields
`define FCS_B_FZ 0
`define FCS_B_AHP 1
`define FCS_B_DN 2
`define FCS_B_RM0 3
`define FCS_B_RM1 4
// interrupt status bits
`define FCS_I_FAULT 0
`define FCS_I_LAZY 1
`define FCS_I_NW 2
// stack frame sizes in words
`define FCS_FRAME_INT 8'h08
`define FCS_FRAME_FP 8'h1a
`define FCS_CTX_WORDS 8'h12
// reset values: unit disabled, lazy stacking
`define FCS_CTRL_RST 3'h4
`define FCS_MODE_RST 5'h00
`endif

//--- src/fcs_pkg.sv
package fcs_pkg;
    typedef enum logic [1:0] {
        fcs_stack_none = 2'h0,
        fcs_stack_full = 2'h1,
        fcs_stack_lazy = 2'h2
    } fcs_stack_t;
    typedef enum logic [1:0] {
        round_to_closest = 2'h0,
        round_upward = 2'h1,
        round_downward = 2'h2,
        round_truncate = 2'h3
    } fcs_round_t;
    typedef enum logic {
        denormal_flush_off = 1'b0,
        denormal_flush_on = 1'b1
    } fcs_flush_t;
    typedef enum logic {
        half_format_standard = 1'b0,
        half_format_extended_range = 1'b1
    } fcs_half_t;
    typedef enum logic {
        nan_pass_through = 1'b0,
        nan_canonical_result = 1'b1
    } fcs_nan_t;
    typedef struct packed {
        fcs_flush_t flush;
        fcs_half_t half;
        fcs_nan_t nan;
        fcs_round_t round;
    } fcs_arith_t;
endpackage

//--- src/fcs_frame_if.sv
interface fcs_frame_if;
    logic entry;
    logic ret;
    logic fp_insn;
    logic save_go;
    logic save_done;
    logic ctx_written;
    logic [7:0] frame_words;
    logic restore;
    modport ctl (output entry, output ret, output fp_insn, input save_go,
        output save_done, input ctx_written, input frame_words, input restore);
    modport frm (input entry, input ret, input fp_insn, output save_go,
        input save_done, output ctx_written, output frame_words, output restore);
endinterface

//--- src/fcs_frame.sv
`include "fcs_cfg.svh"
// per-exception frame tracker: latched stacking mode, lazy save, restore
module fcs_frame (
    input wire logic clk,
    input wire logic nrst,
    input fcs_pkg::fcs_stack_t mode,
    fcs_frame_if.frm fi
);
    fcs_pkg::fcs_stack_t fmode_ff, nxt_fmode;
    logic active_ff, nxt_active;
    logic written_ff, nxt_written;
    logic pend_ff, nxt_pend;

    // frame state: mode is sampled only at entry
    always_comb begin
        nxt_fmode = fmode_ff;
        nxt_active = active_ff;
        nxt_written = written_ff;
        nxt_pend = pend_ff;
        if (fi.entry) begin
            nxt_fmode = mode;
            nxt_active = 1'b1;
            nxt_written = (mode == fcs_pkg::fcs_stack_full);
            nxt_pend = 1'b0;
        end else if (fi.ret) begin
            nxt_active = 1'b0;
            nxt_written = 1'b0;
            nxt_pend = 1'b0;
        end else if (active_ff && fmode_ff == fcs_pkg::fcs_stack_lazy && !written_ff) begin
            if (fi.fp_insn) nxt_pend = 1'b1;
            if (fi.save_done) begin
                nxt_written = 1'b1;
                nxt_pend = 1'b0;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            fmode_ff <= fcs_pkg::fcs_stack_lazy;
            active_ff <= 1'b0;
            written_ff <= 1'b0;
            pend_ff <= 1'b0;
        end else begin
            fmode_ff <= nxt_fmode;
            active_ff <= nxt_active;
            written_ff <= nxt_written;
            pend_ff <= nxt_pend;
        end
    end

    // lazy save request holds the instruction until the context is written
    assign fi.save_go = active_ff && fmode_ff == fcs_pkg::fcs_stack_lazy && !written_ff
        && (fi.fp_insn || pend_ff);
    assign fi.ctx_written = written_ff;
    assign fi.restore = fi.ret && active_ff && written_ff;
    // frame size follows the current stacking mode, not the one latched at entry
    assign fi.frame_words = (mode == fcs_pkg::fcs_stack_none) ? `FCS_FRAME_INT
        : `FCS_FRAME_FP;

    a_restore_only_written: assert property (@(posedge clk) disable iff (!nrst)
        fi.restore |-> written_ff) else $error("restore without saved context");
    a_full_entry_written: assert property (@(posedge clk) disable iff (!nrst)
        fi.entry && mode == fcs_pkg::fcs_stack_full |=> written_ff)
        else $error("full stacking not marked written");
    a_lazy_entry_empty: assert property (@(posedge clk) disable iff (!nrst)
        fi.entry && mode == fcs_pkg::fcs_stack_lazy |=> !written_ff && active_ff)
        else $error("lazy entry wrote context");
    a_mode_frozen: assert property (@(posedge clk) disable iff (!nrst)
        active_ff && !fi.entry |=> $stable(fmode_ff))
        else $error("frame mode changed mid frame");
endmodule

//--- testbench/fcs_core_model.sv
// core side: writes the floating-point context when asked, after a set delay
module fcs_core_model (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [2:0] dly,
    input wire logic save_now,
    output logic save_done
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [2:0] cnt_ff;
    // count the write time, then report done for exactly one cycle
    always_ff @(posedge clk) begin
        if (!nrst) begin
            cnt_ff <= 3'h0;
            save_done <= 1'b0;
        end else if (save_done) begin
            save_done <= 1'b0;
            cnt_ff <= 3'h0;
        end else if (save_now) begin
            if (cnt_ff == dly) begin
                save_done <= 1'b1;
            end else begin
                cnt_ff <= cnt_ff + 3'h1;
            end
        end
    end
endmodule

//--- testbench/tb.sv
`include "fcs_cfg.svh"
module tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk, nrst, reg_wr, reg_rd, fp_issue, exc_entry, exc_return;
    logic fp_go, fp_stall, coprocessor_absent_fault, fp_save_now, fp_save_done;
    logic fp_restore, irq;
    logic [3:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata, rd_val;
    logic [7:0] frame_words, fp_save_words;
    logic [2:0] dly;
    fcs_pkg::fcs_arith_t arith_mode;
    int err_total = 0;
    int n_checks = 0;

    fcs_top DUT (.clk(clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .fp_issue(fp_issue),
        .fp_go(fp_go), .fp_stall(fp_stall), .coprocessor_absent_fault(coprocessor_absent_fault),
        .exc_entry(exc_entry), .exc_return(exc_return), .frame_words(frame_words),
        .fp_save_words(fp_save_words), .fp_save_now(fp_save_now),
        .fp_save_done(fp_save_done), .fp_restore(fp_restore), .arith_mode(arith_mode),
        .irq(irq));
    fcs_core_model CORE (.clk(clk), .nrst(nrst), .dly(dly), .save_now(fp_save_now),
        .save_done(fp_save_done));

    // free-running 100 MHz clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_checks++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic print_verdict();
        $display("checks %0d errors %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic bus_wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    task automatic bus_rd(input logic [3:0] a);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(negedge clk);
        rd_val = reg_rdata;
    endtask

    task automatic exc_in();
        @(posedge clk);
        exc_entry <= 1'b1;
        @(posedge clk);
        exc_entry <= 1'b0;
    endtask

    task automatic exc_out(input logic exp_rst);
        @(posedge clk);
        exc_return <= 1'b1;
        @(negedge clk);
        chk(32'(fp_restore), 32'(exp_rst), "restore on return");
        @(posedge clk);
        exc_return <= 1'b0;
    endtask

    // issue one instruction on an enabled unit, expecting a lazy save or not
    task automatic fp_run(input logic exp_stall);
        int i;
        @(posedge clk);
        fp_issue <= 1'b1;
        @(negedge clk);
        chk(32'(fp_stall), 32'(exp_stall), "stall");
        chk(32'(fp_save_now), 32'(exp_stall), "save request");
        for (i = 0; i < 20 && fp_go !== 1'b1; i++) @(negedge clk);
        chk(32'(fp_go), 32'h1, "instruction executes");
        @(posedge clk);
        fp_issue <= 1'b0;
    endtask

    task automatic t_reset();
        bus_rd(`FCS_A_CTRL);
        chk(rd_val, 32'(`FCS_CTRL_RST), "ctrl reset");
        chk(32'(frame_words), 32'(`FCS_FRAME_FP), "reset frame");
        chk(32'(fp_save_words), 32'(`FCS_FRAME_FP - `FCS_FRAME_INT), "context words");
        chk(32'(arith_mode), 32'h0, "reset arith");
        bus_rd(4'hf);
        chk(rd_val, 32'h0, "unmapped read");
    endtask

    task automatic t_fault();
        bus_wr(`FCS_A_IEN, 32'h1);
        @(posedge clk);
        fp_issue <= 1'b1;
        @(negedge clk);
        chk(32'(fp_go), 32'h0, "blocked while off");
        @(posedge clk);
        fp_issue <= 1'b0;
        @(negedge clk);
        chk(32'(coprocessor_absent_fault), 32'h1, "fault");
        @(negedge clk);
        chk(32'(irq), 32'h1, "irq raised");
        bus_wr(`FCS_A_IEN, 32'h0);
        @(negedge clk);
        chk(32'(irq), 32'h0, "irq masked");
        bus_wr(`FCS_A_IEN, 32'h1);
        bus_wr(`FCS_A_ICLR, 32'h1);
        @(negedge clk);
        chk(32'(irq), 32'h0, "irq cleared");
    endtask

    task automatic t_arith();
        logic [4:0] w;
        for (int v = 0; v < 32; v++) begin
            bus_wr(`FCS_A_MODE, 32'(v));
            bus_rd(`FCS_A_MODE);
            chk(rd_val, 32'(v), "mode readback");
        end
        w = 5'h17;
        bus_wr(`FCS_A_MODE, 32'(w));
        bus_wr(`FCS_A_CTRL, 32'h5);
        fp_run(1'b0);
        @(negedge clk);
        chk(32'(arith_mode), 32'({w[0], w[1], w[2], w[4:3]}), "arith applied");
        bus_wr(`FCS_A_MODE, 32'h0);
        @(negedge clk);
        chk(32'(arith_mode), 32'({w[0], w[1], w[2], w[4:3]}), "late write");
        bus_rd(`FCS_A_ISTAT);
        chk(32'(rd_val[2]), 32'h1, "late write flagged");
    endtask

    task automatic t_stack();
        bus_wr(`FCS_A_CTRL, 32'h1);
        @(negedge clk);
        chk(32'(frame_words), 32'(`FCS_FRAME_INT), "no-stack frame");
        bus_rd(`FCS_A_STAT);
        chk(32'(rd_val[9:2]), 32'(`FCS_FRAME_INT), "frame in status");
        exc_in();
        fp_run(1'b0);
        exc_out(1'b0);
        bus_wr(`FCS_A_CTRL, 32'h3);
        @(negedge clk);
        chk(32'(frame_words), 32'(`FCS_FRAME_FP), "full frame");
        exc_in();
        fp_run(1'b0);
        exc_out(1'b1);
        bus_wr(`FCS_A_CTRL, 32'h5);
        exc_in();
        @(negedge clk);
        chk(32'(fp_save_now), 32'h0, "lazy entry writes nothing");
        chk(32'(frame_words), 32'(`FCS_FRAME_FP), "lazy frame");
        exc_out(1'b0);
        exc_in();
        fp_run(1'b1);
        bus_rd(`FCS_A_STAT);
        chk(32'(rd_val[1:0]), 32'h3, "context written and locked");
        exc_out(1'b1);
        bus_wr(`FCS_A_ICLR, 32'h7);
        dly <= 3'h4;
        exc_in();
        bus_wr(`FCS_A_CTRL, 32'h1);
        @(negedge clk);
        chk(32'(frame_words), 32'(`FCS_FRAME_INT), "new mode for next entry");
        fp_run(1'b1);
        bus_rd(`FCS_A_ISTAT);
        chk(32'(rd_val[1]), 32'h1, "lazy save flagged");
        exc_out(1'b1);
        exc_in();
        fp_run(1'b0);
        exc_out(1'b0);
    endtask

    // main sequence
    initial begin
        nrst = 1'b0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 4'h0;
        reg_wdata = 32'h0;
        fp_issue = 1'b0;
        exc_entry = 1'b0;
        exc_return = 1'b0;
        dly = 3'h0;
        repeat (10) @(posedge clk);
        nrst <= 1'b1;
        t_reset();
        t_fault();
        t_arith();
        t_stack();
        print_verdict();
    end

    // watchdog against a hang
    initial begin
        repeat (20000) @(posedge clk);
        err_total++;
        $display("[ERR] %0t watchdog expired", $time);
        print_verdict();
    end
endmodule
